/* dsm_pkg.sv */
package dsm_pkg;
  // drive state machine states
  typedef enum logic [3:0] {
    ST_NOT_READY,
    ST_SWITCH_ON_DISABLED,
    ST_READY,
    ST_SWITCHED_ON,
    ST_OP_ENABLED,
    ST_QUICK_STOP,
    ST_FAULT_REACTION,
    ST_FAULT
  } dsm_state_e;

  // command word bit positions
  localparam int unsigned CMD_SWITCH_ON   = 0;
  localparam int unsigned CMD_EN_VOLTAGE  = 1;
  localparam int unsigned CMD_QUICK_STOP  = 2;
  localparam int unsigned CMD_EN_OP       = 3;
  localparam int unsigned CMD_FAULT_RESET = 7;
  localparam int unsigned CMD_HALT        = 8;

  // status word bit positions
  localparam int unsigned STS_READY       = 0;
  localparam int unsigned STS_SWITCHED_ON = 1;
  localparam int unsigned STS_OP_ENABLED  = 2;
  localparam int unsigned STS_FAULT       = 3;
  localparam int unsigned STS_VOLTAGE     = 4;
  localparam int unsigned STS_QUICK_STOP  = 5;
  localparam int unsigned STS_SW_ON_DIS   = 6;
  localparam int unsigned STS_WARNING     = 7;
  localparam int unsigned STS_REMOTE      = 9;
  localparam int unsigned STS_TARGET      = 10;
  localparam int unsigned STS_INT_LIMIT   = 11;
  localparam int unsigned STS_MODE_LO     = 12;
  localparam int unsigned STS_MODE_ERR    = 13;
  localparam int unsigned STS_MFR_LO      = 14;

  // operating mode codes
  localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
  localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
  localparam logic [7:0] MODE_PROFILE_TRQ = 8'h04;
  localparam logic [7:0] MODE_HOMING      = 8'h06;

  // reset values
  localparam logic [15:0] CMD_RESET  = 16'h0000;
  localparam logic [7:0]  MODE_RESET = 8'h00;

  // cyclic input image byte of the mode readback
  localparam int unsigned MODE_READBACK_BYTE = 2;

  // parameter indices of the mode objects
  localparam logic [15:0] MODE_SELECT_PARAM_INDEX   = 16'h0080;
  localparam logic [15:0] MODE_READBACK_PARAM_INDEX = 16'h029E;
endpackage : dsm_pkg

/* dsm_mode_reg.sv */
module dsm_mode_reg
  import dsm_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       wr_in,
  input  wire logic [7:0] data_in,
  output logic      [7:0] sel_out,
  output logic      [7:0] active_out
);
  logic       known_w;
  assign known_w = (data_in == MODE_PROFILE_POS) || (data_in == MODE_PROFILE_VEL) ||
                   (data_in == MODE_PROFILE_TRQ) || (data_in == MODE_HOMING);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sel_out    <= MODE_RESET;
      active_out <= MODE_RESET;
    end else if (wr_in) begin
      sel_out <= data_in;
      if (known_w) begin
        active_out <= data_in;
      end
    end
  end
endmodule : dsm_mode_reg

/* dsm_ctrl.sv */
// Summary of operation
// - not ready 0, disabled bit6, ready bits0,5
// - switched-on, enabled, quick-stop status codes
// - fault reaction bits0-3, fault bit3 only
// - fault state keeps power stage off
// - quick stop halts, powered, refuses motion
// - motion only when operation enabled
// - bit4 bus voltage; gates disabled-to-ready
// - bit7 warning, no state change
// - bit9 set while fieldbus has control
// - bit10 target reached, bit11 internal limit
// - bit13 only for blocking error
// - command bits 0-3 steer main transitions
// - bit1 low disables; bit2 low quick stop
// - command changes act immediately
// - bit8 halt; bits4-6 mode specific
// - mode select 1,3,4,6
// - active mode readback, cyclic byte 2
// - command word in, status word out
module dsm_ctrl
  import dsm_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        cmd_wr_in,
  input  wire logic [15:0] cmd_data_in,
  input  wire logic        mode_wr_in,
  input  wire logic [7:0]  mode_data_in,
  input  wire logic        init_done_in,
  input  wire logic        bus_voltage_ok_in,
  input  wire logic        warning_in,
  input  wire logic        fieldbus_remote_in,
  input  wire logic        target_reached_in,
  input  wire logic        internal_limit_in,
  input  wire logic        mode_bit12_in,
  input  wire logic        blocking_error_in,
  input  wire logic [1:0]  mfr_bits_in,
  input  wire logic        internal_fault_in,
  input  wire logic        standstill_in,
  output logic      [15:0] host_command_word_out,
  output logic      [15:0] drive_state_report_word_out,
  output logic      [7:0]  operating_mode_select_out,
  output logic      [7:0]  active_mode_readback_out,
  output logic             power_stage_on_out,
  output logic             motion_enable_out,
  output logic             ramp_to_zero_out,
  output logic             halt_out,
  output logic      [2:0]  mode_bits_out
);
  dsm_state_e  state_q;
  dsm_state_e  state_d;
  logic [15:0] cmd_q;
  logic        fr_prev_q;
  logic [15:0] cmd_w;
  logic        sw_on_w;
  logic        en_volt_w;
  logic        qs_n_w;
  logic        en_op_w;
  logic        fr_rise_w;
  logic        shutdown_w;
  logic        switch_on_w;
  logic        enable_op_w;
  logic        quick_stop_w;
  logic [15:0] status_d;
  logic        fr_bit_w;
  logic        nxt_op_en_w;
  logic        power_d_w;
  logic        ramp_d_w;
  logic        halt_d_w;
  logic [2:0]  mode_bits_d_w;

  // state bits 6:0 of the status word
  function automatic logic [6:0] state_code(input dsm_state_e st);
    logic [6:0] code;
    code = 7'h00;
    unique case (st)
      ST_NOT_READY:          code = 7'h00;
      ST_SWITCH_ON_DISABLED: code[STS_SW_ON_DIS] = 1'b1;
      ST_READY:              code = 7'h21;
      ST_SWITCHED_ON:        code = 7'h23;
      ST_OP_ENABLED:         code = 7'h27;
      ST_QUICK_STOP:         code = 7'h07;
      ST_FAULT_REACTION:     code = 7'h0F;
      ST_FAULT:              code = 7'h08;
      default:               code = 7'h00;
    endcase
    return code;
  endfunction : state_code

  // power stage energised while holding or braking the load
  function automatic logic powered(input dsm_state_e st);
    return (st == ST_OP_ENABLED) || (st == ST_QUICK_STOP) || (st == ST_FAULT_REACTION);
  endfunction : powered

  // controlled ramp toward standstill
  function automatic logic braking(input dsm_state_e st);
    return (st == ST_QUICK_STOP) || (st == ST_FAULT_REACTION);
  endfunction : braking

  // the new word takes effect in the same cycle it is written
  assign cmd_w        = cmd_wr_in ? cmd_data_in : cmd_q;
  assign sw_on_w      = cmd_w[CMD_SWITCH_ON];
  assign en_volt_w    = cmd_w[CMD_EN_VOLTAGE];
  assign qs_n_w       = cmd_w[CMD_QUICK_STOP];
  assign en_op_w      = cmd_w[CMD_EN_OP];
  assign fr_bit_w     = cmd_w[CMD_FAULT_RESET];
  assign fr_rise_w    = fr_bit_w & ~fr_prev_q;
  assign shutdown_w   = en_volt_w & qs_n_w & ~sw_on_w;
  assign switch_on_w  = en_volt_w & qs_n_w & sw_on_w & ~en_op_w;
  assign enable_op_w  = en_volt_w & qs_n_w & sw_on_w & en_op_w;
  assign quick_stop_w = en_volt_w & ~qs_n_w;

  // next-state decodes for the registered outputs
  assign nxt_op_en_w   = (state_d == ST_OP_ENABLED);
  assign power_d_w     = powered(state_d);
  assign ramp_d_w      = braking(state_d);
  assign halt_d_w      = cmd_w[CMD_HALT] & nxt_op_en_w;
  assign mode_bits_d_w = cmd_w[6:4];

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_NOT_READY: begin
        if (init_done_in) begin
          state_d = ST_SWITCH_ON_DISABLED;
        end
      end
      ST_SWITCH_ON_DISABLED: begin
        if (shutdown_w && bus_voltage_ok_in) begin
          state_d = ST_READY;
        end
      end
      ST_READY: begin
        if (internal_fault_in) begin
          state_d = ST_FAULT_REACTION;
        end else if (!en_volt_w || quick_stop_w) begin
          state_d = ST_SWITCH_ON_DISABLED;
        end else if (switch_on_w || enable_op_w) begin
          state_d = ST_SWITCHED_ON;
        end
      end
      ST_SWITCHED_ON: begin
        if (internal_fault_in) begin
          state_d = ST_FAULT_REACTION;
        end else if (!en_volt_w || quick_stop_w) begin
          state_d = ST_SWITCH_ON_DISABLED;
        end else if (shutdown_w) begin
          state_d = ST_READY;
        end else if (enable_op_w) begin
          state_d = ST_OP_ENABLED;
        end
      end
      ST_OP_ENABLED: begin
        if (internal_fault_in) begin
          state_d = ST_FAULT_REACTION;
        end else if (!en_volt_w) begin
          state_d = ST_SWITCH_ON_DISABLED;
        end else if (quick_stop_w) begin
          state_d = ST_QUICK_STOP;
        end else if (shutdown_w) begin
          state_d = ST_READY;
        end else if (switch_on_w) begin
          state_d = ST_SWITCHED_ON;
        end
      end
      ST_QUICK_STOP: begin
        if (internal_fault_in) begin
          state_d = ST_FAULT_REACTION;
        end else if (!en_volt_w) begin
          state_d = ST_SWITCH_ON_DISABLED;
        end else if (enable_op_w) begin
          state_d = ST_OP_ENABLED;
        end
      end
      ST_FAULT_REACTION: begin
        if (standstill_in) begin
          state_d = ST_FAULT;
        end
      end
      ST_FAULT: begin
        if (fr_rise_w) begin
          state_d = ST_SWITCH_ON_DISABLED;
        end
      end
      default: state_d = ST_NOT_READY;
    endcase
  end

  // status word; bit 8 reserved reads zero
  always_comb begin
    status_d = 16'h0000;
    status_d[6:0]           = state_code(state_d);
    status_d[STS_VOLTAGE]   = bus_voltage_ok_in;
    status_d[STS_WARNING]   = warning_in;
    status_d[STS_REMOTE]    = fieldbus_remote_in;
    status_d[STS_TARGET]    = target_reached_in;
    status_d[STS_INT_LIMIT] = internal_limit_in;
    status_d[STS_MODE_LO]   = mode_bit12_in;
    status_d[STS_MODE_ERR]  = blocking_error_in;
    status_d[15:STS_MFR_LO] = mfr_bits_in;
  end

  // state register
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= ST_NOT_READY;
    end else begin
      state_q <= state_d;
    end
  end

  // command word as last written
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cmd_q <= CMD_RESET;
    end else begin
      cmd_q <= cmd_w;
    end
  end

  // fault reset reference for edge detection
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fr_prev_q <= 1'b0;
    end else begin
      fr_prev_q <= fr_bit_w;
    end
  end

  // status word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_state_report_word_out <= 16'h0000;
    end else begin
      drive_state_report_word_out <= status_d;
    end
  end

  // command word readback
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      host_command_word_out <= CMD_RESET;
    end else begin
      host_command_word_out <= cmd_w;
    end
  end

  // power stage drive
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      power_stage_on_out <= 1'b0;
    end else begin
      power_stage_on_out <= power_d_w;
    end
  end

  // motion permission
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      motion_enable_out <= 1'b0;
    end else begin
      motion_enable_out <= nxt_op_en_w;
    end
  end

  // ramp toward standstill
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ramp_to_zero_out <= 1'b0;
    end else begin
      ramp_to_zero_out <= ramp_d_w;
    end
  end

  // halt request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      halt_out <= 1'b0;
    end else begin
      halt_out <= halt_d_w;
    end
  end

  // mode-specific command bits
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mode_bits_out <= 3'h0;
    end else begin
      mode_bits_out <= mode_bits_d_w;
    end
  end

  // mode selection and active mode readback
  dsm_mode_reg u_mode (
    .clk_in     (clk_in),
    .rst_in     (rst_in),
    .wr_in      (mode_wr_in),
    .data_in    (mode_data_in),
    .sel_out    (operating_mode_select_out),
    .active_out (active_mode_readback_out)
  );
endmodule : dsm_ctrl

/* dsm_ctrl_chk_sva.sv */
module dsm_ctrl_chk (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        cmd_wr_in,
  input wire logic [15:0] cmd_data_in,
  input wire logic        bus_voltage_ok_in,
  input wire logic        fieldbus_remote_in,
  input wire logic        internal_fault_in,
  input wire logic        standstill_in,
  input wire logic [15:0] host_command_word_out,
  input wire logic [15:0] drive_state_report_word_out,
  input wire logic        power_stage_on_out,
  input wire logic        motion_enable_out,
  input wire logic        ramp_to_zero_out,
  input wire logic        halt_out
);
  wire logic [15:0] s;
  wire logic        en;
  wire logic        son;
  assign s   = drive_state_report_word_out;
  assign en  = s[6:5] == 2'b01 && s[3:0] == 4'h7;
  assign son = s[6:5] == 2'b01 && s[3:0] == 4'h3;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence s_fault_reset;
    s[3:0] == 4'h8 && cmd_wr_in && cmd_data_in[7] && !host_command_word_out[7];
  endsequence
  sequence s_qstop_cmd;
    en && cmd_wr_in && cmd_data_in[2:1] == 2'b01 && !internal_fault_in;
  endsequence
  sequence s_enable_cmd;
    son && cmd_wr_in && cmd_data_in[3:0] == 4'hF && !internal_fault_in;
  endsequence
  AST_MOTION: assert property (motion_enable_out |-> en)
    else $error("motion outside enabled state");
  AST_FAULT_OFF: assert property (s[3:0] == 4'h8 |-> !power_stage_on_out)
    else $error("power stage on in fault");
  AST_QSTOP: assert property (s[6:5] == 2'b00 && s[3:0] == 4'h7 |-> power_stage_on_out && ramp_to_zero_out && !motion_enable_out)
    else $error("quick stop outputs wrong");
  AST_VOLT: assert property (1'b1 |=> s[4] == $past(bus_voltage_ok_in))
    else $error("voltage bit wrong");
  AST_NO_READY: assert property (s[6] && !bus_voltage_ok_in |=> !s[0])
    else $error("ready without voltage");
  AST_REMOTE: assert property (1'b1 |=> s[9] == $past(fieldbus_remote_in))
    else $error("remote bit wrong");
  AST_HALT: assert property (halt_out |-> en && host_command_word_out[8])
    else $error("halt without cause");
  AST_FAULT_RESET: assert property (s_fault_reset |=> s[6:5] == 2'b10 && s[3:0] == 4'h0)
    else $error("fault reset not taken");
  AST_QSTOP_IN: assert property (s_qstop_cmd |=> s[6:5] == 2'b00 && s[3:0] == 4'h7)
    else $error("quick stop not entered");
  AST_ENABLE: assert property (s_enable_cmd |=> en)
    else $error("enable not taken");
  AST_REACT: assert property (en && internal_fault_in |=> s[3:0] == 4'hF)
    else $error("fault reaction not entered");
  AST_SETTLE: assert property (s[3:0] == 4'hF && standstill_in |=> s[3:0] == 4'h8)
    else $error("fault not settled");
endmodule : dsm_ctrl_chk

bind dsm_ctrl dsm_ctrl_chk u_chk (.clk_in, .rst_in, .cmd_wr_in, .cmd_data_in,
  .bus_voltage_ok_in, .fieldbus_remote_in, .internal_fault_in, .standstill_in,
  .host_command_word_out, .drive_state_report_word_out, .power_stage_on_out,
  .motion_enable_out, .ramp_to_zero_out, .halt_out);

/* dsm_host_model.sv */
module dsm_host_model (
  input  wire logic        clk_in,
  output logic             cmd_wr_out,
  output logic      [15:0] cmd_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_wr_out   = 1'b0;
    cmd_data_out = 16'h0000;
  end
  // one cyclic command write; reserved bits always sent as zero
  task automatic send(input logic [15:0] w);
    @(posedge clk_in);
    #1;
    cmd_wr_out   = 1'b1;
    cmd_data_out = w & 16'h01FF;
    @(posedge clk_in);
    #1;
    cmd_wr_out   = 1'b0;
  endtask : send
endmodule : dsm_host_model

/* tb_drive_state_machine_ctrl.sv */
module tb_drive_state_machine_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, rst_in, cmd_wr_in, mode_wr_in, init_done_in, bus_voltage_ok_in;
  logic        warning_in, fieldbus_remote_in, target_reached_in, internal_limit_in;
  logic        mode_bit12_in, blocking_error_in, internal_fault_in, standstill_in;
  logic        power_stage_on_out, motion_enable_out, ramp_to_zero_out, halt_out;
  logic [1:0]  mfr_bits_in;
  logic [2:0]  mode_bits_out;
  logic [7:0]  mode_data_in, operating_mode_select_out, active_mode_readback_out;
  logic [15:0] cmd_data_in, host_command_word_out, drive_state_report_word_out;
  wire  [15:0] sts = drive_state_report_word_out;
  int          mismatches = 0;
  int          num_checks = 0;
  dsm_ctrl DUT (
    .clk_in                      (clk_in),
    .rst_in                      (rst_in),
    .cmd_wr_in                   (cmd_wr_in),
    .cmd_data_in                 (cmd_data_in),
    .mode_wr_in                  (mode_wr_in),
    .mode_data_in                (mode_data_in),
    .init_done_in                (init_done_in),
    .bus_voltage_ok_in           (bus_voltage_ok_in),
    .warning_in                  (warning_in),
    .fieldbus_remote_in          (fieldbus_remote_in),
    .target_reached_in           (target_reached_in),
    .internal_limit_in           (internal_limit_in),
    .mode_bit12_in               (mode_bit12_in),
    .blocking_error_in           (blocking_error_in),
    .mfr_bits_in                 (mfr_bits_in),
    .internal_fault_in           (internal_fault_in),
    .standstill_in               (standstill_in),
    .host_command_word_out       (host_command_word_out),
    .drive_state_report_word_out (drive_state_report_word_out),
    .operating_mode_select_out   (operating_mode_select_out),
    .active_mode_readback_out    (active_mode_readback_out),
    .power_stage_on_out          (power_stage_on_out),
    .motion_enable_out           (motion_enable_out),
    .ramp_to_zero_out            (ramp_to_zero_out),
    .halt_out                    (halt_out),
    .mode_bits_out               (mode_bits_out)
  );
  dsm_host_model host (.clk_in, .cmd_wr_out(cmd_wr_in), .cmd_data_out(cmd_data_in));
  function automatic logic [15:0] outs();
    return {12'h000, halt_out, power_stage_on_out, motion_enable_out, ramp_to_zero_out};
  endfunction : outs
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic cmd(input logic [15:0] w, input logic [15:0] e);
    host.send(w);
    chk("status", e, sts);
  endtask : cmd
  task automatic print_verdict;
    if (mismatches == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic t_start;
    repeat (4) tick();
    rst_in = 1'b0;
    chk("outs", 16'h0000, outs());
    chk("status", 16'h0000, sts);
    tick();
    chk("status", 16'h0000, sts);
    init_done_in = 1'b1;
    tick();
    chk("status", 16'h0040, sts);
    cmd(16'h0006, 16'h0040);
    cmd(16'h0000, 16'h0040);
    bus_voltage_ok_in = 1'b1;
    tick();
    chk("status", 16'h0050, sts);
  endtask : t_start
  task automatic t_flags;
    for (int k = 0; k < 8; k++) begin
      {mfr_bits_in, blocking_error_in, mode_bit12_in, internal_limit_in,
       target_reached_in, fieldbus_remote_in, warning_in} = 8'(1 << k);
      tick();
      chk("flags", 16'h0050 | (16'h0080 << (k == 0 ? 0 : k + 1)), sts);
    end
    {mfr_bits_in, blocking_error_in} = '0;
  endtask : t_flags
  task automatic t_walk;
    cmd(16'h0006, 16'h0031);
    cmd(16'h0007, 16'h0033);
    chk("outs", 16'h0000, outs());
    cmd(16'h000F, 16'h0037);
    chk("outs", 16'h0006, outs());
    cmd(16'hFD5F, 16'h0037);
    chk("outs", 16'h000E, outs());
    chk("mbits", 16'h0005, 16'(mode_bits_out));
    chk("cmd", 16'h015F, host_command_word_out);
    cmd(16'h0007, 16'h0033);
    chk("outs", 16'h0000, outs());
  endtask : t_walk
  task automatic t_qstop;
    cmd(16'h000F, 16'h0037);
    cmd(16'h000B, 16'h0017);
    chk("outs", 16'h0005, outs());
    cmd(16'h000F, 16'h0037);
    cmd(16'h000B, 16'h0017);
    cmd(16'h0000, 16'h0050);
    cmd(16'h0006, 16'h0031);
    cmd(16'h000F, 16'h0033);
    cmd(16'h0006, 16'h0031);
    cmd(16'h0003, 16'h0050);
  endtask : t_qstop
  task automatic t_fault;
    cmd(16'h0006, 16'h0031);
    cmd(16'h0007, 16'h0033);
    cmd(16'h000F, 16'h0037);
    internal_fault_in = 1'b1;
    tick();
    chk("status", 16'h001F, sts);
    chk("outs", 16'h0005, outs());
    standstill_in = 1'b1;
    tick();
    chk("status", 16'h0018, sts);
    chk("outs", 16'h0000, outs());
    internal_fault_in = 1'b0;
    standstill_in = 1'b0;
    cmd(16'h000F, 16'h0018);
    cmd(16'h008F, 16'h0050);
  endtask : t_fault
  task automatic t_mode;
    logic [7:0] codes [4] = '{8'h01, 8'h03, 8'h04, 8'h06};
    mode_wr_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      mode_data_in = codes[i];
      tick();
      chk("mode", {codes[i], codes[i]}, {operating_mode_select_out, active_mode_readback_out});
    end
    mode_data_in = 8'h05;
    tick();
    mode_wr_in = 1'b0;
    chk("mode", 16'h0506, {operating_mode_select_out, active_mode_readback_out});
  endtask : t_mode
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    rst_in = 1'b1;
    {mode_wr_in, init_done_in, bus_voltage_ok_in, warning_in, fieldbus_remote_in, target_reached_in,
     internal_limit_in, mode_bit12_in, blocking_error_in, internal_fault_in, standstill_in,
     mfr_bits_in, mode_data_in} = '0;
    t_start();
    t_flags();
    t_walk();
    t_qstop();
    t_fault();
    t_mode();
    print_verdict();
  end
  initial begin
    repeat (5000) @(posedge clk_in);
    mismatches++;
    print_verdict();
  end
endmodule : tb_drive_state_machine_ctrl
